//--- hdl/cdrcr_regs.svh
// Register offsets, field positions and reset values of the per-channel control bank
`ifndef CDRCR_REGS_SVH
`define CDRCR_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define CDRCR_CH0_CTRL        8'h08
`define CDRCR_CH0_CFG         8'h09
`define CDRCR_CH0_STAT        8'h0A
`define CDRCR_CH1_CTRL        8'h10
`define CDRCR_CH1_CFG         8'h11
`define CDRCR_CH1_STAT        8'h12
`define CDRCR_CH2_CTRL        8'h18
`define CDRCR_CH2_CFG         8'h19
`define CDRCR_CH2_STAT        8'h1A
`define CDRCR_CH3_CTRL        8'h20
`define CDRCR_CH3_CFG         8'h21
`define CDRCR_CH3_STAT        8'h22
`define CDRCR_MAX_CH          4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CDRCR_CTRL_CLK_OFF    2
`define CDRCR_CTRL_CDR_OFF    1
`define CDRCR_CTRL_POL        0
`define CDRCR_CFG_RATE_HI     5
`define CDRCR_CFG_RATE_LO     4
`define CDRCR_CFG_LOL_IE      1
`define CDRCR_CFG_LOS_IE      0
`define CDRCR_STAT_LOL        5
`define CDRCR_STAT_LOS        4
`define CDRCR_STAT_LOL_IS     1
`define CDRCR_STAT_LOS_IS     0

// ----------------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------------
`define CDRCR_CTRL_MASK       8'h07
`define CDRCR_CFG_MASK        8'h33
`define CDRCR_CTRL_RESET      8'h00
`define CDRCR_CFG_RESET       8'h00

`endif

//--- hdl/cdrcr_pkg.sv
// Types shared by the per-channel control bank
package cdrcr_pkg;

	// Decoded line rate of one channel
	typedef enum logic [1:0] {
		CDRCR_RATE_LOW,
		CDRCR_RATE_MID,
		CDRCR_RATE_HIGH
	} cdrcr_rate_t;

	// Software-visible settings of one channel
	typedef struct packed {
		logic       recovered_clock_output_off;
		logic       recovery_unit_off;
		logic       signal_detect_polarity;
		logic       line_rate_sel_hi;
		logic       line_rate_sel_lo;
		logic       lock_loss_irq_enable;
		logic       signal_loss_irq_enable;
	} cdrcr_chan_cfg_t;

	// Host register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cdrcr_req_t;

endpackage : cdrcr_pkg

//--- hdl/cdrcr_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps

module cdrcr_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : cdrcr_sync

//--- hdl/cdrcr_channel.sv
// Registers and change flags of one recovery channel
`timescale 1ns/1ps
`include "cdrcr_regs.svh"

module cdrcr_channel (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic                       wr_ctrl_i,
	input  wire logic                       wr_cfg_i,
	input  wire logic                       rd_stat_i,
	input  wire logic [7:0]                 wdata_i,
	input  wire logic                       lock_loss_i,
	input  wire logic                       signal_loss_i,
	output cdrcr_pkg::cdrcr_chan_cfg_t      cfg_o,
	output logic      [7:0]                 ctrl_rd_o,
	output logic      [7:0]                 cfg_rd_o,
	output logic      [7:0]                 stat_rd_o,
	output logic                            irq_o
);
	import cdrcr_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] cfg_q;
	logic       lol_prev_q;
	logic       los_prev_q;
	logic       primed_q;
	logic       lol_flag_q;
	logic       los_flag_q;
	logic       lol_chg;
	logic       los_chg;

	// Control register, reserved bits masked off
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			ctrl_q <= `CDRCR_CTRL_RESET;
		else if (wr_ctrl_i)
			ctrl_q <= wdata_i & `CDRCR_CTRL_MASK;
	end

	// Configuration and enable register
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			cfg_q <= `CDRCR_CFG_RESET;
		else if (wr_cfg_i)
			cfg_q <= wdata_i & `CDRCR_CFG_MASK;
	end

	// Previous state, primed so reset release raises no flag
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			lol_prev_q <= 1'b0;
			los_prev_q <= 1'b0;
			primed_q   <= 1'b0;
		end
		else
		begin
			lol_prev_q <= lock_loss_i;
			los_prev_q <= signal_loss_i;
			primed_q   <= 1'b1;
		end
	end

	assign lol_chg = primed_q && (lock_loss_i != lol_prev_q);
	assign los_chg = primed_q && (signal_loss_i != los_prev_q);

	// Sticky change flags; a change in the read cycle wins
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			lol_flag_q <= 1'b0;
			los_flag_q <= 1'b0;
		end
		else
		begin
			lol_flag_q <= lol_chg | (lol_flag_q & ~rd_stat_i);
			los_flag_q <= los_chg | (los_flag_q & ~rd_stat_i);
		end
	end

	assign ctrl_rd_o = ctrl_q;
	assign cfg_rd_o  = cfg_q;
	assign stat_rd_o = {2'b00, lock_loss_i, signal_loss_i, 2'b00, lol_flag_q, los_flag_q};

	assign cfg_o.recovered_clock_output_off = ctrl_q[`CDRCR_CTRL_CLK_OFF];
	assign cfg_o.recovery_unit_off          = ctrl_q[`CDRCR_CTRL_CDR_OFF];
	assign cfg_o.signal_detect_polarity     = ctrl_q[`CDRCR_CTRL_POL];
	assign cfg_o.line_rate_sel_hi           = cfg_q[`CDRCR_CFG_RATE_HI];
	assign cfg_o.line_rate_sel_lo           = cfg_q[`CDRCR_CFG_RATE_LO];
	assign cfg_o.lock_loss_irq_enable       = cfg_q[`CDRCR_CFG_LOL_IE];
	assign cfg_o.signal_loss_irq_enable     = cfg_q[`CDRCR_CFG_LOS_IE];

	assign irq_o = (lol_flag_q & cfg_q[`CDRCR_CFG_LOL_IE]) | (los_flag_q & cfg_q[`CDRCR_CFG_LOS_IE]);

endmodule : cdrcr_channel

//--- hdl/cdrcr_top.sv
// Per-channel control, configuration and change-status registers of the quad recovery device
//
// Behaviour
// - Each of the four channels has its own control register at 0x08, 0x10, 0x18 and 0x20.
// - Control bit 2 set to one tristates the channel's recovered clock pair, zero keeps it driven.
// - Control bit 1 set to one disables the channel's recovery unit, zero enables it.
// - Control bit 0 picks the signal detect polarity: zero means low is present, one means high is present.
// - Each channel has a configuration and interrupt enable register at 0x09, 0x11, 0x19 and 0x21.
// - Bits 5:4 pick the channel's line rate: 00 lowest, 01 middle, 10 and 11 highest.
// - Configuration bit 1 enables the lock loss interrupt when one and masks it when zero.
// - Configuration bit 0 enables the signal loss interrupt when one and masks it when zero.
// - Unused bits of both registers read zero and ignore writes.
// - The lock loss flag sets on any lock state change, clears on read, and interrupts only when enabled.
// - The signal loss flag sets on any signal state change, clears on read, and interrupts only when enabled.
`timescale 1ns/1ps
`include "cdrcr_regs.svh"

module cdrcr_top #(
	parameter int NUM_CH = 4
) (
	input  wire logic                                core_clk_i,
	input  wire logic                                rst_n_i,
	// Host register port
	input  wire logic                                reg_wr_i,
	input  wire logic                                reg_rd_i,
	input  wire logic [7:0]                          reg_addr_i,
	input  wire logic [7:0]                          reg_wdata_i,
	output logic      [7:0]                          reg_rdata_o,
	output logic                                     reg_rvalid_o,
	output logic                                     reg_wack_o,
	output logic                                     reg_unmapped_o,
	// Channel pins and recovery loop status
	input  wire logic [NUM_CH-1:0]                   external_signal_detect_i,
	input  wire logic [NUM_CH-1:0]                   lock_loss_i,
	input  wire logic [NUM_CH-1:0]                   internal_signal_loss_i,
	output logic      [NUM_CH-1:0]                   recovered_clock_out_pair_oe_o,
	output logic      [NUM_CH-1:0]                   recovery_unit_off_o,
	output cdrcr_pkg::cdrcr_rate_t [NUM_CH-1:0]      line_rate_o,
	output logic      [NUM_CH-1:0]                   signal_present_o,
	output logic      [NUM_CH-1:0]                   signal_loss_o,
	output logic                                     irq_o
);
	import cdrcr_pkg::*;

	// ------------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------------

	// Only four channel slots exist in the address map
	if (NUM_CH < 1 || NUM_CH > `CDRCR_MAX_CH)
	begin : g_bad_num_ch
		$error("cdrcr_top: NUM_CH must lie between 1 and 4");
	end

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------

	cdrcr_req_t                  req;
	cdrcr_chan_cfg_t [NUM_CH-1:0] chan_cfg;
	logic            [NUM_CH-1:0] hit_ctrl;
	logic            [NUM_CH-1:0] hit_cfg;
	logic            [NUM_CH-1:0] hit_stat;
	logic            [NUM_CH-1:0] wr_ctrl;
	logic            [NUM_CH-1:0] wr_cfg;
	logic            [NUM_CH-1:0] rd_stat;
	logic            [7:0]        ctrl_rd  [NUM_CH];
	logic            [7:0]        cfg_rd   [NUM_CH];
	logic            [7:0]        stat_rd  [NUM_CH];
	logic            [NUM_CH-1:0] chan_irq;
	logic            [NUM_CH-1:0] detect_sync;
	logic            [NUM_CH-1:0] lock_loss_sync;
	logic            [NUM_CH-1:0] int_loss_sync;
	logic            [NUM_CH-1:0] present;
	logic            [NUM_CH-1:0] loss_state;
	logic            [7:0]        rdata_d;
	logic                         mapped;
	logic            [7:0]        reg_rdata_q;
	logic                         reg_rvalid_q;
	logic                         reg_wack_q;
	logic                         reg_unmapped_q;
	logic            [NUM_CH-1:0] clk_oe_q;
	logic            [NUM_CH-1:0] cdr_off_q;
	cdrcr_rate_t     [NUM_CH-1:0] rate_q;
	logic            [NUM_CH-1:0] present_q;
	logic            [NUM_CH-1:0] loss_q;
	logic                         irq_q;

	// ------------------------------------------------------------------------
	// Address helpers
	// ------------------------------------------------------------------------

	// Control offset of a channel slot
	function automatic logic [7:0] ctrl_ofs(input int ch);
		logic [7:0] ofs;
		ofs = `CDRCR_CH0_CTRL;
		case (ch)
			1:       ofs = `CDRCR_CH1_CTRL;
			2:       ofs = `CDRCR_CH2_CTRL;
			3:       ofs = `CDRCR_CH3_CTRL;
			default: ofs = `CDRCR_CH0_CTRL;
		endcase
		return ofs;
	endfunction : ctrl_ofs

	// Configuration offset of a channel slot
	function automatic logic [7:0] cfg_ofs(input int ch);
		logic [7:0] ofs;
		ofs = `CDRCR_CH0_CFG;
		case (ch)
			1:       ofs = `CDRCR_CH1_CFG;
			2:       ofs = `CDRCR_CH2_CFG;
			3:       ofs = `CDRCR_CH3_CFG;
			default: ofs = `CDRCR_CH0_CFG;
		endcase
		return ofs;
	endfunction : cfg_ofs

	// Status offset of a channel slot
	function automatic logic [7:0] stat_ofs(input int ch);
		logic [7:0] ofs;
		ofs = `CDRCR_CH0_STAT;
		case (ch)
			1:       ofs = `CDRCR_CH1_STAT;
			2:       ofs = `CDRCR_CH2_STAT;
			3:       ofs = `CDRCR_CH3_STAT;
			default: ofs = `CDRCR_CH0_STAT;
		endcase
		return ofs;
	endfunction : stat_ofs

	// two high codes share the top rate
	function automatic cdrcr_rate_t rate_decode(input logic hi, input logic lo);
		cdrcr_rate_t r;
		r = CDRCR_RATE_LOW;
		case ({hi, lo})
			2'b00:   r = CDRCR_RATE_LOW;
			2'b01:   r = CDRCR_RATE_MID;
			2'b10:   r = CDRCR_RATE_HIGH;
			2'b11:   r = CDRCR_RATE_HIGH;
			default: r = CDRCR_RATE_LOW;
		endcase
		return r;
	endfunction : rate_decode

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------

	// Detect pin comes from the optical module, off our clock
	cdrcr_sync #(
		.WIDTH (NUM_CH)
	) u_sync_detect (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (external_signal_detect_i),
		.sync_o     (detect_sync)
	);

	// Lock indication from the recovery loop, on its own timing
	cdrcr_sync #(
		.WIDTH (NUM_CH)
	) u_sync_lock (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (lock_loss_i),
		.sync_o     (lock_loss_sync)
	);

	// Internal signal loss detector, same reasoning
	cdrcr_sync #(
		.WIDTH (NUM_CH)
	) u_sync_los (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.async_i    (internal_signal_loss_i),
		.sync_o     (int_loss_sync)
	);

	// ------------------------------------------------------------------------
	// Request decode
	// ------------------------------------------------------------------------

	assign req.wr    = reg_wr_i;
	assign req.rd    = reg_rd_i;
	assign req.addr  = reg_addr_i;
	assign req.wdata = reg_wdata_i;

	// Per-channel address hits and strobes
	always_comb
	begin
		hit_ctrl = '0;
		hit_cfg  = '0;
		hit_stat = '0;
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			hit_ctrl[ch] = (req.addr == ctrl_ofs(ch));
			hit_cfg[ch]  = (req.addr == cfg_ofs(ch));
			hit_stat[ch] = (req.addr == stat_ofs(ch));
		end
	end

	// Status is read-only, so a write there only acknowledges
	assign wr_ctrl = hit_ctrl & {NUM_CH{req.wr}};
	assign wr_cfg  = hit_cfg  & {NUM_CH{req.wr}};
	assign rd_stat = hit_stat & {NUM_CH{req.rd}};
	assign mapped  = |{hit_ctrl, hit_cfg, hit_stat};

	// ------------------------------------------------------------------------
	// Channel state
	// ------------------------------------------------------------------------

	// Signal present and loss state per channel
	always_comb
	begin
		present    = '0;
		loss_state = '0;
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			present[ch]    = chan_cfg[ch].signal_detect_polarity ? detect_sync[ch] : ~detect_sync[ch];
			loss_state[ch] = int_loss_sync[ch] | ~present[ch];
		end
	end

	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_chan
		cdrcr_channel u_chan (
			.core_clk_i    (core_clk_i),
			.rst_n_i       (rst_n_i),
			.wr_ctrl_i     (wr_ctrl[g]),
			.wr_cfg_i      (wr_cfg[g]),
			.rd_stat_i     (rd_stat[g]),
			.wdata_i       (req.wdata),
			.lock_loss_i   (lock_loss_sync[g]),
			.signal_loss_i (loss_state[g]),
			.cfg_o         (chan_cfg[g]),
			.ctrl_rd_o     (ctrl_rd[g]),
			.cfg_rd_o      (cfg_rd[g]),
			.stat_rd_o     (stat_rd[g]),
			.irq_o         (chan_irq[g])
		);
	end

	// ------------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------------

	// Unmapped addresses read zero
	always_comb
	begin
		rdata_d = 8'h00;
		for (int ch = 0; ch < NUM_CH; ch++)
		begin
			if (hit_ctrl[ch])
				rdata_d = ctrl_rd[ch];
			else if (hit_cfg[ch])
				rdata_d = cfg_rd[ch];
			else if (hit_stat[ch])
				rdata_d = stat_rd[ch];
		end
	end

	// Read data and answer strobes, one cycle after the request
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			reg_rdata_q    <= 8'h00;
			reg_rvalid_q   <= 1'b0;
			reg_wack_q     <= 1'b0;
			reg_unmapped_q <= 1'b0;
		end
		else
		begin
			reg_rvalid_q   <= req.rd;
			reg_wack_q     <= req.wr;
			reg_unmapped_q <= (req.rd | req.wr) & ~mapped;
			// Data held until the next read
			if (req.rd)
				reg_rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------------

	// Registered so pins never see decode glitches, at one cycle of latency
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			clk_oe_q  <= '1;
			cdr_off_q <= '0;
			rate_q    <= '{default: CDRCR_RATE_LOW};
			present_q <= '0;
			loss_q    <= '0;
		end
		else
		begin
			for (int ch = 0; ch < NUM_CH; ch++)
			begin
				clk_oe_q[ch]  <= ~chan_cfg[ch].recovered_clock_output_off;
				cdr_off_q[ch] <= chan_cfg[ch].recovery_unit_off;
				rate_q[ch]    <= rate_decode(chan_cfg[ch].line_rate_sel_hi, chan_cfg[ch].line_rate_sel_lo);
			end
			present_q <= present;
			loss_q    <= loss_state;
		end
	end

	// Any channel raises the shared interrupt
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			irq_q <= 1'b0;
		else
			irq_q <= |chan_irq;
	end

	assign reg_rdata_o                   = reg_rdata_q;
	assign reg_rvalid_o                  = reg_rvalid_q;
	assign reg_wack_o                    = reg_wack_q;
	assign reg_unmapped_o                = reg_unmapped_q;
	assign recovered_clock_out_pair_oe_o = clk_oe_q;
	assign recovery_unit_off_o           = cdr_off_q;
	assign line_rate_o                   = rate_q;
	assign signal_present_o              = present_q;
	assign signal_loss_o                 = loss_q;
	assign irq_o                         = irq_q;

endmodule : cdrcr_top

//--- test/cdrcr_line_model.sv
// Line-side partner: optical module signal detect and recovery loop status
`timescale 1ns/1ps

module cdrcr_line_model #(
	parameter int NUM_CH = 4
) (
	input  wire logic              core_clk_i,
	input  wire logic [NUM_CH-1:0] lock_loss_cmd_i,
	input  wire logic [NUM_CH-1:0] signal_loss_cmd_i,
	input  wire logic [NUM_CH-1:0] detect_cmd_i,
	input  wire logic [NUM_CH-1:0] recovery_unit_off_i,
	output logic      [NUM_CH-1:0] lock_loss_o = '0,
	output logic      [NUM_CH-1:0] internal_signal_loss_o = '0,
	output logic      [NUM_CH-1:0] external_signal_detect_o = '0
);
	// ------------------------------------------------------------------
	// Status levels
	// ------------------------------------------------------------------
	// stopped loop reports out of lock
	// raw detect level, polarity is the device's job
	// Updated on the rising edge so the device sees them settled
	always @(posedge core_clk_i)
	begin
		lock_loss_o              <= lock_loss_cmd_i | recovery_unit_off_i;
		internal_signal_loss_o   <= signal_loss_cmd_i;
		external_signal_detect_o <= detect_cmd_i;
	end
endmodule : cdrcr_line_model

//--- test/cdrcr_top_sva.sv
// Port checker for the per-channel control bank
`timescale 1ns/1ps

module cdrcr_top_sva #(
	parameter int NUM_CH = 4
) (
	input wire logic                           core_clk_i,
	input wire logic                           rst_n_i,
	input wire logic                           reg_wr_i,
	input wire logic                           reg_rd_i,
	input wire logic [7:0]                     reg_addr_i,
	input wire logic [7:0]                     reg_wdata_i,
	input wire logic [7:0]                     reg_rdata_o,
	input wire logic                           reg_rvalid_o,
	input wire logic                           reg_wack_o,
	input wire logic                           reg_unmapped_o,
	input wire logic [NUM_CH-1:0]              recovered_clock_out_pair_oe_o,
	input wire logic [NUM_CH-1:0]              recovery_unit_off_o,
	input wire cdrcr_pkg::cdrcr_rate_t [NUM_CH-1:0] line_rate_o,
	input wire logic                           irq_o
);
	import cdrcr_pkg::*;

	// Control and config addresses of all four channels
	logic mapped;
	assign mapped = reg_addr_i inside {8'h08, 8'h09, 8'h10, 8'h11, 8'h18, 8'h19, 8'h20, 8'h21};

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	wr_ack_a: assert property (reg_wr_i && mapped |=> reg_wack_o && !reg_unmapped_o)
		else $error("write to a mapped register not acknowledged");
	rd_valid_a: assert property (reg_rd_i && mapped |=> reg_rvalid_o && !reg_unmapped_o)
		else $error("read of a mapped register not answered");
	unmapped_a: assert property (reg_rd_i && reg_addr_i == 8'h30 |=> reg_unmapped_o && reg_rdata_o == 8'h00)
		else $error("unmapped read not flagged or not zero");
	clk_gate_a: assert property (reg_wr_i && reg_addr_i == 8'h08 |-> ##2
		recovered_clock_out_pair_oe_o[0] == !$past(reg_wdata_i[2], 2))
		else $error("clock pair enable does not follow control bit 2");
	cdr_off_a: assert property (reg_wr_i && reg_addr_i == 8'h08 |-> ##2
		recovery_unit_off_o[0] == $past(reg_wdata_i[1], 2))
		else $error("recovery off does not follow control bit 1");
	rate_sel_a: assert property (reg_wr_i && reg_addr_i == 8'h09 |-> ##2 line_rate_o[0] ==
		($past(reg_wdata_i[5], 2) ? CDRCR_RATE_HIGH : $past(reg_wdata_i[4], 2) ? CDRCR_RATE_MID : CDRCR_RATE_LOW))
		else $error("line rate does not follow config bits 5:4");
	ctrl_resv_a: assert property (reg_rd_i && reg_addr_i[2:0] == 3'h0 |=> (reg_rdata_o & 8'hF8) == 8'h00)
		else $error("control reserved bits read nonzero");
	cfg_resv_a: assert property (reg_rd_i && reg_addr_i[2:0] == 3'h1 |=> (reg_rdata_o & 8'hCC) == 8'h00)
		else $error("config reserved bits read nonzero");
	reset_idle_a: assert property ($rose(rst_n_i) |-> (&recovered_clock_out_pair_oe_o) &&
		recovery_unit_off_o == '0 && !irq_o)
		else $error("outputs not idle at reset release");
endmodule : cdrcr_top_sva

bind cdrcr_top cdrcr_top_sva #(.NUM_CH(NUM_CH)) cdrcr_top_sva_inst (
	.core_clk_i                    (core_clk_i),
	.rst_n_i                       (rst_n_i),
	.reg_wr_i                      (reg_wr_i),
	.reg_rd_i                      (reg_rd_i),
	.reg_addr_i                    (reg_addr_i),
	.reg_wdata_i                   (reg_wdata_i),
	.reg_rdata_o                   (reg_rdata_o),
	.reg_rvalid_o                  (reg_rvalid_o),
	.reg_wack_o                    (reg_wack_o),
	.reg_unmapped_o                (reg_unmapped_o),
	.recovered_clock_out_pair_oe_o (recovered_clock_out_pair_oe_o),
	.recovery_unit_off_o           (recovery_unit_off_o),
	.line_rate_o                   (line_rate_o),
	.irq_o                         (irq_o)
);

//--- test/tb_cdrcr_top.sv
// Self-checking bench for the per-channel control bank
`timescale 1ns/1ps

module tb_cdrcr_top;
	import cdrcr_pkg::*;

	logic              core_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              wr = 1'b0;
	logic              rd = 1'b0;
	logic [7:0]        addr = 8'h00;
	logic [7:0]        wdata = 8'h00;
	logic [7:0]        rdata;
	logic              rvalid, wack, unmapped, irq;
	logic [3:0]        oe, off, present, lock_loss, los_int, det, sloss;
	logic [3:0]        lol_cmd = '0;
	logic [3:0]        los_cmd = '0;
	logic [3:0]        det_cmd = '0;
	cdrcr_rate_t [3:0] rate;
	int                fail_count = 0;
	int                num_checks = 0;

	// 40 MHz core clock
	always #12.5 core_clk = ~core_clk;

	cdrcr_top #(.NUM_CH(4)) cdrcr_top_inst (
		.core_clk_i(core_clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.reg_wack_o(wack), .reg_unmapped_o(unmapped), .external_signal_detect_i(det),
		.lock_loss_i(lock_loss), .internal_signal_loss_i(los_int), .recovered_clock_out_pair_oe_o(oe),
		.recovery_unit_off_o(off), .line_rate_o(rate), .signal_present_o(present),
		.signal_loss_o(sloss), .irq_o(irq));

	// Detect pin low unless a test raises it for one channel
	cdrcr_line_model #(.NUM_CH(4)) cdrcr_line_model_inst (
		.core_clk_i(core_clk), .lock_loss_cmd_i(lol_cmd), .signal_loss_cmd_i(los_cmd),
		.detect_cmd_i(det_cmd), .recovery_unit_off_i(off), .lock_loss_o(lock_loss),
		.internal_signal_loss_o(los_int), .external_signal_detect_o(det));

	// ------------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------------
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk8

	// Strobes rise after a falling edge and drop one cycle later
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge core_clk);
		wr = 1'b0;
		chk8("write ack", 8'h01, {7'h00, wack});
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		rd = 1'b1;
		addr = a;
		@(negedge core_clk);
		rd = 1'b0;
		d = rdata;
	endtask : rd_reg

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk8("read valid", 8'h01, {7'h00, rvalid});
		chk8($sformatf("read %h", a), exp, d);
	endtask : rd_chk

	// Change one status level and let it cross the synchroniser
	task automatic toggle(input int ch, input int w);
		if (w == 1)
			lol_cmd[ch] = ~lol_cmd[ch];
		else
			los_cmd[ch] = ~los_cmd[ch];
		repeat (6) @(negedge core_clk);
	endtask : toggle

	// Change flag, clear on read and interrupt mask; w 1 lock, 0 signal
	task automatic evt(input int ch, input int w);
		logic [7:0] st;
		logic [7:0] junk;
		st = 8'(8 * ch + 10);
		wr_reg(st - 8'h01, 8'h00);
		repeat (8) @(negedge core_clk);
		rd_reg(st, junk);
		toggle(ch, w);
		chk8("irq masked", 8'h00, {7'h00, irq});
		rd_chk(st, 8'h11 << w);
		rd_chk(st, 8'h10 << w);
		wr_reg(st - 8'h01, 8'h01 << w);
		toggle(ch, w);
		chk8("irq enabled", 8'h01, {7'h00, irq});
		rd_chk(st, 8'h01 << w);
		@(negedge core_clk);
		chk8("irq cleared", 8'h00, {7'h00, irq});
	endtask : evt

	// Reset for 20 cycles, then every writable field reads zero
	task automatic do_reset();
		rst_n = 1'b0;
		repeat (20) @(negedge core_clk);
		rst_n = 1'b1;
		for (int ch = 0; ch < 4; ch++)
		begin
			rd_chk(8'(8 * ch + 8), 8'h00);
			rd_chk(8'(8 * ch + 9), 8'h00);
			chk8("rate", 8'h00, {6'h00, rate[ch]});
		end
		chk8("pair enables", 8'h0F, {4'h0, oe});
		chk8("recovery off", 8'h00, {4'h0, off});
		chk8("irq", 8'h00, {7'h00, irq});
	endtask : do_reset

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		logic [7:0] c;
		do_reset();
		for (int ch = 0; ch < 4; ch++)
		begin
			c = 8'(8 * ch + 8);
			wr_reg(c, 8'hFF);
			rd_chk(c, 8'h07);
			chk8("pair enable", 8'h00, {7'h00, oe[ch]});
			chk8("recovery off", 8'h01, {7'h00, off[ch]});
			chk8("present", 8'h00, {7'h00, present[ch]});
			chk8("signal loss", 8'h01, {7'h00, sloss[ch]});
			// Detect high now counts as present
			det_cmd[ch] = 1'b1;
			repeat (6) @(negedge core_clk);
			chk8("present high", 8'h01, {7'h00, present[ch]});
			chk8("signal loss", 8'h00, {7'h00, sloss[ch]});
			det_cmd[ch] = 1'b0;
			wr_reg(c, 8'h00);
			rd_chk(c, 8'h00);
			chk8("pair enable", 8'h01, {7'h00, oe[ch]});
			chk8("recovery off", 8'h00, {7'h00, off[ch]});
			chk8("present", 8'h01, {7'h00, present[ch]});
			chk8("signal loss", 8'h00, {7'h00, sloss[ch]});
			// Every rate code, reserved bits set on each write
			for (int r = 0; r < 4; r++)
			begin
				wr_reg(c + 8'h01, 8'(r << 4) | 8'hCF);
				rd_chk(c + 8'h01, 8'(r << 4) | 8'h03);
				chk8("rate", (r == 0) ? 8'h00 : (r == 1) ? 8'h01 : 8'h02, {6'h00, rate[ch]});
			end
			evt(ch, 1);
			evt(ch, 0);
		end
		rd_chk(8'h30, 8'h00);
		chk8("unmapped", 8'h01, {7'h00, unmapped});
		// Second reset over dirty registers
		wr_reg(8'h20, 8'h07);
		wr_reg(8'h21, 8'h33);
		do_reset();
		conclude();
	end

	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		fail_count++;
		conclude();
	end
endmodule : tb_cdrcr_top
